// file: hw/imsr_sequencer.sv
//----------------------------------------------------------------------
// Purpose : Integrate/measure sequencer with serial result readout
// Assumes : All inputs synchronous to i_clock
// Notes   : Results come in as signed samples through a 4-word FIFO
//----------------------------------------------------------------------
`timescale 1ns/1ps

//----------------------------------------------------------------------
// Sample FIFO
//----------------------------------------------------------------------
module imsr_fifo #(
    parameter int unsigned WIDTH = 20,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             i_clock,
    input  wire logic             i_sys_rst,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int unsigned PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr_ptr;
        logic [PTR_W-1:0]            rd_ptr;
        logic [PTR_W:0]              count;
    } imsr_fifo_t;

    imsr_fifo_t fifo;
    imsr_fifo_t next_fifo;
    logic       push;
    logic       pop;

    // Full refuses a push even when a pop lands in the same cycle
    assign o_in_ready  = (fifo.count != DEPTH[PTR_W:0]);
    assign o_out_valid = (fifo.count != '0);
    assign o_out_data  = fifo.mem[fifo.rd_ptr];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_comb
    begin
        next_fifo = fifo;
        if (push)
        begin
            next_fifo.mem[fifo.wr_ptr] = i_in_data;
            next_fifo.wr_ptr = (fifo.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : fifo.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            next_fifo.rd_ptr = (fifo.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : fifo.rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            next_fifo.count = fifo.count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_fifo.count = fifo.count - 1'b1;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            fifo <= '0;
        end
        else
        begin
            fifo <= next_fifo;
        end
    end
endmodule

//----------------------------------------------------------------------
// Sequencer and readout
//----------------------------------------------------------------------
module imsr_sequencer
    import imsr_pkg::*;
(
    input  wire logic                       i_clock,
    input  wire logic                       i_sys_rst,
    input  wire logic                       i_side_select_level,
    input  wire logic                       i_prescale_by_four,
    input  wire logic                       i_word_width_select,
    input  wire logic                       i_shift_clock,
    input  wire logic                       i_chain_in,
    input  wire logic                       i_sample_valid,
    input  wire logic [imsr_pkg::WORD_W-1:0] i_sample_data,
    output logic                            o_sample_ready,
    output logic                            o_data_ready_n,
    output logic                            o_serial_out,
    output logic                            o_input_ground,
    output logic                            o_integrating,
    output logic                            o_integrate_side,
    output logic [2:0]                      o_state_number
);
    import imsr_pkg::*;

    typedef struct packed {
        imsr_state_t                         state;
        logic                                side_prev;
        logic                                next_side;
        logic                                integ_side;
        logic [1:0]                          pend;
        logic [CNT_W-1:0]                    busy_cnt;
        logic [CH_W-1:0]                     meas_ch;
        logic                                new_data;
        logic [CNT_W-1:0]                    rdy_cnt;
        logic                                rdy_pend;
        logic                                ready_n;
        logic                                shclk_prev;
        logic                                clk_rose;
        logic [NUM_CHANNELS-1:0][WORD_W-1:0] meas;
        logic [NUM_CHANNELS-1:0][WORD_W-1:0] rd;
        logic                                wide;
        logic [BIT_W-1:0]                    bitpos;
        logic [CH_W-1:0]                     rd_ch;
        logic                                chaining;
        logic                                sout;
    } imsr_seq_t;

    imsr_seq_t         seq;
    imsr_seq_t         next_seq;
    logic              toggle;
    logic              cycle_busy;
    logic              fifo_valid;
    logic [WORD_W-1:0] fifo_data;
    logic              fifo_take;
    logic              shclk_fall;
    logic              shclk_rise;
    logic [CNT_W-1:0]  meas_dur;
    logic [CNT_W-1:0]  ready_dur;
    logic [BIT_W-1:0]  lsb_pos;

    // Signed sample to saturated offset-binary code
    // Saturating, so a large negative sample reads as zero, not a wrap
    function automatic logic [WORD_W-1:0] imsr_encode(input logic [WORD_W-1:0] sample);
        logic signed [WORD_W+1:0] sum;
        sum = $signed({sample[WORD_W-1], sample[WORD_W-1], sample})
              + $signed({1'b0, RESULT_OFFSET});
        if (sum < 0)
        begin
            return '0;
        end
        else if (sum > $signed({1'b0, RESULT_MAX}))
        begin
            return RESULT_MAX[WORD_W-1:0];
        end
        return sum[WORD_W-1:0];
    endfunction

    // True in the grounded, stalled-regime states
    function automatic logic imsr_is_stalled(input imsr_state_t st);
        return (st == ST_WAIT_HI) || (st == ST_PREP_HI)
            || (st == ST_PREP_LO) || (st == ST_WAIT_LO);
    endfunction

    imsr_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clock     (i_clock),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (i_sample_valid),
        .i_in_data   (i_sample_data),
        .o_in_ready  (o_sample_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (fifo_take)
    );

    // Level compare with the last sample; a toggle lasts one cycle
    assign toggle     = (i_side_select_level != seq.side_prev);
    assign cycle_busy = (seq.busy_cnt != '0) || (seq.pend != 2'h0);
    // Measurement only drains samples; outside it the FIFO fills and stalls the source
    assign fifo_take  = (seq.busy_cnt != '0) && (seq.meas_ch <= LAST_CHANNEL)
                        && !seq.new_data;
    assign shclk_fall = seq.shclk_prev && !i_shift_clock;
    assign shclk_rise = !seq.shclk_prev && i_shift_clock;
    // Prescale stretches sequencer timing only; the readout is host-paced
    assign meas_dur   = i_prescale_by_four ? (MEASURE_CYCLE_DURATION << PRESCALE_SHIFT)
                                           : MEASURE_CYCLE_DURATION;
    assign ready_dur  = i_prescale_by_four ? (TOGGLE_TO_READY_DELAY << PRESCALE_SHIFT)
                                           : TOGGLE_TO_READY_DELAY;
    assign lsb_pos    = seq.wide ? LSB_POS_WIDE : LSB_POS_NARROW;

    //------------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------------
    always_comb
    begin
        next_seq            = seq;
        next_seq.side_prev  = i_side_select_level;
        next_seq.shclk_prev = i_shift_clock;

        // Measurement engine
        // Starting a new cycle drops results that were never snapshotted
        if (seq.busy_cnt != '0)
        begin
            next_seq.busy_cnt = seq.busy_cnt - 1'b1;
            if (seq.busy_cnt == 14'h0001)
            begin
                next_seq.new_data = 1'b1;
            end
        end
        else if (seq.pend != 2'h0)
        begin
            next_seq.busy_cnt = meas_dur;
            next_seq.pend     = seq.pend - 1'b1;
            next_seq.meas_ch  = '0;
            next_seq.new_data = 1'b0;
        end
        if (fifo_take && fifo_valid)
        begin
            next_seq.meas[seq.meas_ch[4:0]] = imsr_encode(fifo_data);
            next_seq.meas_ch = seq.meas_ch + 1'b1;
        end

        // Level-driven state progression
        unique case (seq.state)
            ST_WAIT_HI, ST_WAIT_LO:
            begin
                // Toggles here only re-pick the mirror; no integration runs
                if (cycle_busy)
                begin
                    next_seq.state = i_side_select_level ? ST_WAIT_HI : ST_WAIT_LO;
                end
                else
                begin
                    next_seq.state = i_side_select_level ? ST_PREP_HI : ST_PREP_LO;
                end
            end
            ST_PREP_HI, ST_PREP_LO:
            begin
                if (toggle)
                begin
                    // First integration after a stall runs with no measurement beside it
                    next_seq.state = i_side_select_level ? ST_INT_ONLY_HI
                                                         : ST_INT_ONLY_LO;
                    next_seq.integ_side = seq.next_side;
                    next_seq.next_side  = !seq.next_side;
                end
            end
            ST_INT_ONLY_LO, ST_OVL_HI, ST_OVL_LO, ST_INT_ONLY_HI:
            begin
                if (toggle)
                begin
                    // Queue a measurement of the side that just finished
                    next_seq.pend = next_seq.pend + 1'b1;
                    if (cycle_busy)
                    begin
                        next_seq.state = i_side_select_level ? ST_WAIT_HI : ST_WAIT_LO;
                    end
                    else
                    begin
                        next_seq.state = i_side_select_level ? ST_OVL_HI : ST_OVL_LO;
                        next_seq.integ_side = seq.next_side;
                        next_seq.next_side  = !seq.next_side;
                    end
                end
            end
        endcase

        // Data-ready timing
        // Each toggle restarts the delay, so ready follows the last one
        if (toggle)
        begin
            next_seq.rdy_cnt  = ready_dur;
            next_seq.rdy_pend = 1'b1;
        end
        else if (seq.rdy_cnt != '0)
        begin
            next_seq.rdy_cnt = seq.rdy_cnt - 1'b1;
        end

        // Readout shifter
        // Shift clock is sampled, so each phase must last a full clock
        if (shclk_rise && !seq.ready_n)
        begin
            next_seq.clk_rose = 1'b1;
        end
        if (shclk_fall)
        begin
            if (!seq.ready_n && seq.clk_rose)
            begin
                next_seq.ready_n  = 1'b1;
                next_seq.clk_rose = 1'b0;
            end
            if (seq.chaining)
            begin
                next_seq.sout = i_chain_in;
            end
            else if (seq.bitpos == lsb_pos)
            begin
                next_seq.bitpos = MSB_POS;
                if (seq.rd_ch == LAST_CHANNEL)
                begin
                    next_seq.chaining = 1'b1;
                    next_seq.sout     = i_chain_in;
                end
                else
                begin
                    next_seq.rd_ch = seq.rd_ch + 1'b1;
                    next_seq.sout  = seq.rd[seq.rd_ch[4:0] + 5'h01][MSB_POS];
                end
            end
            else
            begin
                next_seq.bitpos = seq.bitpos - 1'b1;
                next_seq.sout   = seq.rd[seq.rd_ch[4:0]][seq.bitpos - 5'h01];
            end
        end

        // Snapshot wins over the shifter: a new result set restarts the readout
        if (seq.rdy_pend && (seq.rdy_cnt == '0) && !toggle && seq.new_data)
        begin
            next_seq.rd       = seq.meas;
            next_seq.rdy_pend = 1'b0;
            next_seq.new_data = 1'b0;
            next_seq.ready_n  = 1'b0;
            next_seq.clk_rose = 1'b0;
            next_seq.wide     = i_word_width_select;
            next_seq.rd_ch    = '0;
            next_seq.bitpos   = MSB_POS;
            next_seq.chaining = 1'b0;
            next_seq.sout     = seq.meas[0][MSB_POS];
        end
    end

    //------------------------------------------------------------------
    // State register
    //------------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            // Synchronous, so the side-select level may be sampled here
            next_seq_reset();
        end
        else
        begin
            seq <= next_seq;
        end
    end

    // Readout idles with ready high and data low until a snapshot
    task automatic next_seq_reset();
        seq            <= '0;
        seq.state      <= i_side_select_level ? ST_WAIT_HI : ST_WAIT_LO;
        seq.side_prev  <= i_side_select_level;
        seq.ready_n    <= 1'b1;
        seq.bitpos     <= MSB_POS;
        seq.shclk_prev <= i_shift_clock;
    endtask

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    assign o_data_ready_n   = seq.ready_n;
    assign o_serial_out     = seq.sout;
    // Decoded from the state register, so neither output glitches
    assign o_input_ground   = imsr_is_stalled(seq.state);
    assign o_integrating    = !imsr_is_stalled(seq.state);
    assign o_integrate_side = seq.integ_side;
    assign o_state_number   = seq.state;
endmodule

// file: hw/imsr_pkg.sv
//----------------------------------------------------------------------
// Summary of operation
// - Sequencer has exactly eight states covering overlapped and stalled regimes.
// - Sequencer advances on side-select level plus internal cycle-busy, not edges.
// - Cycle-busy is high while any measurement cycle runs; it stays internal.
// - Overlapped operation uses states 3 to 6, chosen by side-select level.
// - States 3 and 6 only integrate; they launch no opposite-side measurement.
// - Side-select change while busy enters or stays in stalled state 1 or 8.
// - When busy ends in a stalled wait, go to preparation state 2 or 7.
// - Stalled states 1, 2, 7 and 8 ground the analogue inputs.
// - Successive integrations always alternate between side A and side B.
// - Start in state 1 when side-select high, 8 when low; pairs mirror.
// - Always start stalled; overlapped only after the first two states.
// - Durations count master-clock periods; prescale by four multiplies them by four.
// - Fixed periods after each side-select transition, data-ready goes low; the code also waits for new_data, so it can go low later.
// - Data-ready stays low until shift clock goes high then low again.
// - Short integration falls back to stalled; pending measurements finish grounded.
// - Long enough integrations return to overlapped; first one may be shorter.
// - Results are offset binary with about 0.4 percent positive full-scale offset.
// - Word-width select 1 gives 20-bit words; 0 drops low 4 bits.
// - Results readable at data-ready fall; bits change on shift clock fall.
// - After own results, chain input bits pass through to serial output.
// - Reset clears the device; host discards first four conversions.
//----------------------------------------------------------------------
// Purpose : Constants and types of the integrate/measure sequencer
// Assumes : 40 MHz master clock
// Notes   : Durations are in master-clock periods
package imsr_pkg;

    localparam int unsigned NUM_CHANNELS = 32;
    localparam int unsigned CH_W         = 6;
    localparam int unsigned WORD_W       = 20;
    localparam int unsigned BIT_W        = 5;
    localparam int unsigned CNT_W        = 14;
    localparam int unsigned FIFO_DEPTH   = 4;

    // Durations in master-clock periods, before prescale
    localparam logic [CNT_W-1:0] MEASURE_CYCLE_DURATION  = 14'h0040;
    localparam logic [CNT_W-1:0] TOGGLE_TO_READY_DELAY   = 14'h0050;
    localparam int unsigned      PRESCALE_SHIFT          = 2;

    // About 0.4 percent of positive full scale
    localparam logic [WORD_W:0]  RESULT_OFFSET  = 21'h001062;
    localparam logic [WORD_W:0]  RESULT_MAX     = 21'h0FFFFF;

    localparam logic [BIT_W-1:0] MSB_POS        = 5'h13;
    localparam logic [BIT_W-1:0] LSB_POS_WIDE   = 5'h00;
    localparam logic [BIT_W-1:0] LSB_POS_NARROW = 5'h04;
    localparam logic [CH_W-1:0]  LAST_CHANNEL   = 6'h1F;

    typedef enum logic [2:0] {
        ST_WAIT_HI,
        ST_PREP_HI,
        ST_INT_ONLY_LO,
        ST_OVL_HI,
        ST_OVL_LO,
        ST_INT_ONLY_HI,
        ST_PREP_LO,
        ST_WAIT_LO
    } imsr_state_t;

endpackage

// file: testbench/imsr_assertions.sv
//------------------------------------------------
// Purpose: Port-level checks of the sequencer
// Assumes: Single clock, synchronous reset
// Notes  : Bound to every sequencer instance
//------------------------------------------------
`timescale 1ns/1ps
module imsr_assertions (
    input wire logic       i_clock,
    input wire logic       i_sys_rst,
    input wire logic       i_side_select_level,
    input wire logic       i_shift_clock,
    input wire logic       o_data_ready_n,
    input wire logic       o_serial_out,
    input wire logic       o_input_ground,
    input wire logic       o_integrating,
    input wire logic       o_integrate_side,
    input wire logic [2:0] o_state_number
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    property p_ground;
        o_input_ground == (o_state_number inside {3'h0, 3'h1, 3'h6, 3'h7});
    endproperty
    a_ground: assert property (p_ground) else $error("ground decode wrong");

    property p_integ;
        o_integrating != o_input_ground;
    endproperty
    a_integ: assert property (p_integ) else $error("integrating flag wrong");

    // Checked through the reset itself, so no disable here
    property p_rst_state;
        disable iff (1'b0)
        i_sys_rst |=> o_state_number == ($past(i_side_select_level) ? 3'h0 : 3'h7);
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("reset state wrong");

    property p_rst_out;
        disable iff (1'b0)
        i_sys_rst |=> o_data_ready_n && !o_serial_out && o_input_ground;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("reset outputs wrong");

    property p_release;
        !o_data_ready_n && $rose(i_shift_clock) ##1 $fell(i_shift_clock)
            |=> o_data_ready_n;
    endproperty
    a_release: assert property (p_release) else $error("ready not released");

    property p_wait_sel;
        o_state_number inside {3'h0, 3'h7} && $changed(i_side_select_level)
            |=> o_state_number == ($past(i_side_select_level) ? 3'h0 : 3'h7);
    endproperty
    a_wait_sel: assert property (p_wait_sel) else $error("wait reselect wrong");

    property p_prep_exit;
        o_state_number inside {3'h1, 3'h6} && $changed(i_side_select_level)
            |=> o_state_number == ($past(i_side_select_level) ? 3'h5 : 3'h2);
    endproperty
    a_prep_exit: assert property (p_prep_exit) else $error("prep exit wrong");

    property p_ovl_level;
        o_state_number inside {3'h3, 3'h4} && $stable(i_side_select_level)
            |-> i_side_select_level == (o_state_number == 3'h3);
    endproperty
    a_ovl_level: assert property (p_ovl_level) else $error("overlap state wrong");

    property p_side_alt;
        o_integrating && $changed(i_side_select_level)
            |=> o_input_ground || (o_integrate_side != $past(o_integrate_side));
    endproperty
    a_side_alt: assert property (p_side_alt) else $error("side not alternating");

    c_ovl: cover property (o_state_number == 3'h3);
    c_stall: cover property (o_state_number == 3'h7);
    c_ready: cover property ($fell(o_data_ready_n));
endmodule

bind imsr_sequencer imsr_assertions CHK (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_side_select_level(i_side_select_level), .i_shift_clock(i_shift_clock),
    .o_data_ready_n(o_data_ready_n), .o_serial_out(o_serial_out),
    .o_input_ground(o_input_ground), .o_integrating(o_integrating),
    .o_integrate_side(o_integrate_side), .o_state_number(o_state_number)
);

// file: testbench/imsr_host_model.sv
//------------------------------------------------
// Purpose: Host controller reading serial results
// Assumes: Host acts at falling clock edges
// Notes  : Shift clock rests low outside a readout
//------------------------------------------------
`timescale 1ns/1ps
module imsr_host_model (
    input  wire logic        i_clock,
    input  wire logic        i_data_ready_n,
    input  wire logic        i_serial_out,
    input  wire logic        i_side_select_level,
    input  wire logic        i_go,
    input  wire logic [15:0] i_nbits,
    input  wire logic [15:0] i_gap,
    output logic             o_shift_clock,
    output logic             o_done
);
    logic bits [$];
    logic last_level;
    int   quiet;
    initial
    begin
        o_shift_clock = 1'b0;
        o_done = 1'b0;
        quiet = 0;
        last_level = 1'b0;
    end
    always @(posedge i_clock)
    begin
        quiet <= (i_side_select_level != last_level) ? 0 : quiet + 1;
        last_level <= i_side_select_level;
    end
    always @(posedge i_go)
    begin
        o_done = 1'b0;
        bits.delete();
        // Noise hazard: no shifting near a level change; poll ready
        while (quiet < 400 || i_data_ready_n !== 1'b0)
            @(negedge i_clock);
        repeat (i_nbits)
        begin
            bits.push_back(i_serial_out);
            o_shift_clock = 1'b1;
            @(negedge i_clock);
            o_shift_clock = 1'b0;
            repeat (i_gap + 16'h0001) @(negedge i_clock);
        end
        o_done = 1'b1;
    end
endmodule

// file: testbench/imsr_sequencer_tb_top.sv
//------------------------------------------------
// Purpose: Self-checking bench of the sequencer
// Assumes: Host model drives the shift clock
// Notes  : Same sample pattern fed every cycle
//------------------------------------------------
`timescale 1ns/1ps
module imsr_sequencer_tb_top;
    import imsr_pkg::*;
    localparam int D = int'(TOGGLE_TO_READY_DELAY);
    logic              clk, rst, lvl, pre, wsel, chn, go, took;
    logic              srdy, drn, sout, gnd, integ, side, sclk, done;
    logic [WORD_W-1:0] sdat;
    logic [2:0]        st;
    logic [15:0]       nb, gap;
    int                num_errors, comparisons, ch;

    imsr_sequencer DUT (
        .i_clock(clk), .i_sys_rst(rst), .i_side_select_level(lvl),
        .i_prescale_by_four(pre), .i_word_width_select(wsel),
        .i_shift_clock(sclk), .i_chain_in(chn), .i_sample_valid(!rst),
        .i_sample_data(sdat), .o_sample_ready(srdy), .o_data_ready_n(drn),
        .o_serial_out(sout), .o_input_ground(gnd), .o_integrating(integ),
        .o_integrate_side(side), .o_state_number(st)
    );
    imsr_host_model HOST (
        .i_clock(clk), .i_data_ready_n(drn), .i_serial_out(sout),
        .i_side_select_level(lvl), .i_go(go), .i_nbits(nb), .i_gap(gap),
        .o_shift_clock(sclk), .o_done(done)
    );

    always #12.5 clk = ~clk;
    assign sdat = (ch == 0) ? 20'hFFFFF : (ch == 1) ? 20'h80000 : 20'(ch);
    always @(posedge clk) took <= !rst && srdy;
    always @(negedge clk) ch = rst ? 0 : took ? (ch + 1) % 32 : ch;

    function automatic logic [31:0] ofs(int k);
        return (k == 0) ? 32'h1061 : (k == 1) ? 32'h0 : k + 32'h1062;
    endfunction
    function automatic logic [31:0] getw(int k, int w);
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < w; i++)
            v = {v[30:0], HOST.bits[k * w + i]};
        return v;
    endfunction
    task automatic check(string what, logic [31:0] seen, logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, want, seen);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic toggle(int w);
        cyc(w);
        lvl = !lvl;
        cyc(2);
    endtask
    task automatic timed(output int n);
        cyc(400);
        lvl = !lvl;
        n = 0;
        while (drn !== 1'b0 && n < 2000)
        begin
            cyc(1);
            n++;
        end
    endtask
    task automatic hread(int n, int g);
        int t;
        nb = 16'(n);
        gap = 16'(g);
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        t = 0;
        while (done !== 1'b1 && t < 20000)
        begin
            cyc(1);
            t++;
        end
        check("read done", done, 1);
    endtask

    task automatic t_reset_high();
        cyc(6);
        check("state", st, 0);
        check("ready_n", drn, 1);
        check("serial", sout, 0);
        check("ground", gnd, 1);
        rst = 1'b0;
        cyc(10);
        check("state", st, 1);
        check("fifo ready", srdy, 0);
        $display("t_reset_high done");
    endtask
    task automatic t_overlap();
        logic s0;
        int   n;
        toggle(0);
        s0 = side;
        check("state", st, 2);
        check("integrating", integ, 1);
        timed(n);
        check("delay ok", n >= D && n <= D + 4, 1);
        check("state", st, 3);
        check("side", side, !s0);
        hread(640, 0);
        check("ch0", getw(0, 20), ofs(0));
        check("ch1", getw(1, 20), ofs(1));
        check("ch31", getw(31, 20), ofs(31));
        check("ready_n", drn, 1);
        toggle(400);
        check("state", st, 4);
        check("side", side, s0);
        $display("t_overlap done");
    endtask
    task automatic t_stalled();
        logic sa;
        toggle(100);
        sa = side;
        check("state", st, 3);
        toggle(0);
        check("state", st, 7);
        check("ground", gnd, 1);
        toggle(1);
        check("state", st, 0);
        toggle(1);
        check("state", st, 7);
        cyc(300);
        check("state", st, 6);
        toggle(0);
        check("state", st, 5);
        check("side", side, !sa);
        toggle(200);
        check("state", st, 4);
        $display("t_stalled done");
    endtask
    task automatic t_narrow_chain();
        int n;
        cyc(400);
        if (drn === 1'b0)
            hread(1, 0);
        pre = 1'b1;
        wsel = 1'b0;
        chn = 1'b1;
        timed(n);
        check("delay x4", n >= 4 * D && n <= 4 * D + 4, 1);
        hread(516, 2);
        check("ch0", getw(0, 16), ofs(0) >> 4);
        check("ch31", getw(31, 16), ofs(31) >> 4);
        check("chain", {HOST.bits[513], HOST.bits[514], HOST.bits[515]}, 7);
        chn = 1'b0;
        pre = 1'b0;
        $display("t_narrow_chain done");
    endtask
    task automatic t_reset_low();
        cyc(400);
        lvl = 1'b0;
        cyc(2);
        rst = 1'b1;
        cyc(2);
        check("state", st, 7);
        check("ready_n", drn, 1);
        rst = 1'b0;
        cyc(2);
        check("state", st, 6);
        $display("t_reset_low done");
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        lvl = 1'b1;
        pre = 1'b0;
        wsel = 1'b1;
        chn = 1'b0;
        go = 1'b0;
        took = 1'b0;
        nb = 16'h0000;
        gap = 16'h0000;
        ch = 0;
        num_errors = 0;
        comparisons = 0;
        t_reset_high();
        t_overlap();
        t_stalled();
        t_narrow_chain();
        t_reset_low();
        close_out();
    end
    // Whole run is near 7000 cycles; cut a hang at 40000
    initial
    begin
        #1000000;
        num_errors++;
        close_out();
    end
endmodule
